// ===== hdl/fclc_map.svh
// Register offsets, command codes, status codes and reset values of the flash command block.
// Assumes a byte-wide register port with 12-bit register file addresses.
`ifndef FCLC_MAP_SVH
`define FCLC_MAP_SVH

`define FCLC_ADDR_CMD       12'hff8
`define FCLC_ADDR_PAGE      12'hff9

`define FCLC_CMD_UNLOCK1    8'h73
`define FCLC_CMD_UNLOCK2    8'h8c
`define FCLC_CMD_PAGE_ERASE 8'h95
`define FCLC_CMD_MASS_ERASE 8'h63
`define FCLC_CMD_GUARD_SEL  8'h5e

`define FCLC_STAT_LOCKED    6'h00
`define FCLC_STAT_FIRST     6'h01
`define FCLC_STAT_SECOND    6'h02
`define FCLC_STAT_UNLOCKED  6'h03
`define FCLC_STAT_GUARD     6'h04
`define FCLC_STAT_PROG      6'h08
`define FCLC_STAT_PERASE    6'h10
`define FCLC_STAT_MERASE    6'h20

`define FCLC_RST_PAGE       8'h00
`define FCLC_RST_GUARD      8'h00
`define FCLC_RST_RDATA      8'h00
`define FCLC_INFO_BIT       7
`define FCLC_PAGE_LSB       9

`endif

// ===== hdl/fclc_pkg.sv
// Types shared by the flash command block files.
// Assumes the constants header is included by the files that need numbers.
`default_nettype none

package fclc_pkg;

    // Controller sequence states.
    typedef enum {
        FCLC_LOCKED,
        FCLC_FIRST,
        FCLC_SECOND,
        FCLC_UNLOCKED,
        FCLC_GUARD_SEL,
        FCLC_PROG,
        FCLC_PERASE,
        FCLC_MERASE
    } fclc_state_e;

    // Memory size configuration of the attached flash array.
    typedef enum logic [1:0] {
        FCLC_MEM_8K = 2'h0,
        FCLC_MEM_4K = 2'h1,
        FCLC_MEM_2K = 2'h2,
        FCLC_MEM_1K = 2'h3
    } fclc_mem_e;

endpackage : fclc_pkg

`default_nettype wire

// ===== hdl/fclc_sector_check.sv
// Maps a program address to its sector and reports whether that sector is guarded.
// Assumes a purely combinational use on the system clock's side.
`default_nettype none

module fclc_sector_check (
    input  wire logic [15:0]       addr,
    input  wire fclc_pkg::fclc_mem_e mem_cfg,
    input  wire logic [7:0]        guard,
    output logic                   hit
);
    import fclc_pkg::*;

    logic [2:0] idx;

    // Sector size is 1024 bytes on the largest array and 512 bytes otherwise.
    always_comb begin
        unique case (mem_cfg)
            FCLC_MEM_8K: idx = addr[12:10];
            FCLC_MEM_4K: idx = addr[11:9];
            FCLC_MEM_2K: idx = {1'b0, addr[10:9]};
            FCLC_MEM_1K: idx = {2'b00, addr[9]};
        endcase
        hit = guard[idx];
    end

endmodule : fclc_sector_check

`default_nettype wire

// ===== hdl/fclc_ctrl.sv
// Flash command, status, page choice and sector guard registers with the unlock sequencer.
// Assumes register writes and program requests come from logic on ref_clk, one per cycle.
`include "fclc_map.svh"
`default_nettype none

module fclc_ctrl (
    input  wire logic                ref_clk,
    input  wire logic                sys_rst,
    input  wire logic [11:0]         reg_addr,
    input  wire logic                reg_wr,
    input  wire logic                reg_rd,
    input  wire logic [7:0]          reg_wdata,
    input  wire logic                debugger_path,
    output logic [7:0]               reg_rdata,
    input  wire fclc_pkg::fclc_mem_e mem_cfg,
    input  wire logic                write_enable_opt,
    input  wire logic                prog_req,
    input  wire logic [15:0]         prog_addr,
    input  wire logic                prog_dbg,
    output logic                     prog_go,
    output logic                     prog_refused,
    input  wire logic                flash_done,
    output logic                     page_erase_go,
    output logic                     mass_erase_go,
    output logic [6:0]               erase_page,
    output logic                     info_map_en
);
    import fclc_pkg::*;

    fclc_state_e state_q, state_d;
    logic [7:0]  page_q, page_d;
    logic [7:0]  guard_q, guard_d;
    logic [7:0]  rdata_q, rdata_d;
    logic        pgo_q, pgo_d;
    logic        prej_q, prej_d;
    logic        pe_q, pe_d;
    logic        me_q, me_d;
    logic        cmd_wr;
    logic        page_wr;
    logic        busy;
    logic        page_prot;
    logic        prog_prot;
    logic        prog_ok;
    logic        erase_ok;

    // Status code for each controller state; low bits of running operations read as zero.
    function automatic logic [5:0] status_of(input fclc_state_e s);
        unique case (s)
            FCLC_LOCKED:    status_of = `FCLC_STAT_LOCKED;
            FCLC_FIRST:     status_of = `FCLC_STAT_FIRST;
            FCLC_SECOND:    status_of = `FCLC_STAT_SECOND;
            FCLC_UNLOCKED:  status_of = `FCLC_STAT_UNLOCKED;
            FCLC_GUARD_SEL: status_of = `FCLC_STAT_GUARD;
            FCLC_PROG:      status_of = `FCLC_STAT_PROG;
            FCLC_PERASE:    status_of = `FCLC_STAT_PERASE;
            FCLC_MERASE:    status_of = `FCLC_STAT_MERASE;
        endcase
    endfunction : status_of

    // Access decode; the debugger qualifier travels with each write.
    assign cmd_wr  = reg_wr && (reg_addr == `FCLC_ADDR_CMD);
    assign page_wr = reg_wr && (reg_addr == `FCLC_ADDR_PAGE);
    assign busy    = (state_q == FCLC_PROG) || (state_q == FCLC_PERASE)
                     || (state_q == FCLC_MERASE);

    // Sector lookups for the active page and for the byte being programmed.
    fclc_sector_check u_page_check (
        .addr    ({page_q[6:0], 9'h000}),
        .mem_cfg (mem_cfg),
        .guard   (guard_q),
        .hit     (page_prot)
    );

    fclc_sector_check u_prog_check (
        .addr    (prog_addr),
        .mem_cfg (mem_cfg),
        .guard   (guard_q),
        .hit     (prog_prot)
    );

    // The debugger bypasses the option bit and guard; user code must hit the open page.
    assign erase_ok = debugger_path || (write_enable_opt && !page_prot);
    assign prog_ok  = prog_dbg
                      || (write_enable_opt && !prog_prot
                          && (prog_addr[15:`FCLC_PAGE_LSB] == page_q[6:0]));

    // Sequencer next state, register updates and one-cycle start pulses.
    always_comb begin
        state_d = state_q;
        page_d  = page_q;
        guard_d = guard_q;
        pgo_d   = 1'b0;
        prej_d  = 1'b0;
        pe_d    = 1'b0;
        me_d    = 1'b0;
        if (busy) begin
            // Writes are ignored while the array works; the CPU idles meanwhile.
            if (flash_done) begin
                if (state_q == FCLC_PROG) begin
                    state_d = FCLC_UNLOCKED;
                end else begin
                    state_d = FCLC_LOCKED;
                end
            end
        end else if (cmd_wr) begin
            state_d = FCLC_LOCKED;
            if (reg_wdata == `FCLC_CMD_GUARD_SEL) begin
                state_d = FCLC_GUARD_SEL;
            end else begin
                unique case (state_q)
                    FCLC_LOCKED, FCLC_GUARD_SEL: begin
                        if (reg_wdata == `FCLC_CMD_UNLOCK1) begin
                            state_d = FCLC_FIRST;
                        end
                    end
                    FCLC_FIRST: begin
                        if (reg_wdata == `FCLC_CMD_UNLOCK2) begin
                            state_d = debugger_path ? FCLC_UNLOCKED
                                                    : FCLC_SECOND;
                        end
                    end
                    FCLC_UNLOCKED: begin
                        if (reg_wdata == `FCLC_CMD_PAGE_ERASE && erase_ok) begin
                            state_d = FCLC_PERASE;
                            pe_d    = 1'b1;
                        end else if (reg_wdata == `FCLC_CMD_MASS_ERASE && debugger_path) begin
                            state_d = FCLC_MERASE;
                            me_d    = 1'b1;
                        end
                    end
                    default: begin
                        state_d = FCLC_LOCKED;
                    end
                endcase
            end
        end else if (page_wr) begin
            unique case (state_q)
                FCLC_GUARD_SEL: begin
                    // User code may only add protection; the debugger may remove it.
                    guard_d = debugger_path ? reg_wdata
                                            : (guard_q | reg_wdata);
                    state_d = FCLC_LOCKED;
                end
                FCLC_SECOND: begin
                    state_d = (reg_wdata == page_q) ? FCLC_UNLOCKED
                                                    : FCLC_LOCKED;
                end
                FCLC_UNLOCKED: begin
                    if (debugger_path) begin
                        page_d = reg_wdata;
                    end
                end
                FCLC_FIRST: begin
                    page_d  = reg_wdata;
                    state_d = FCLC_LOCKED;
                end
                default: begin
                    page_d = reg_wdata;
                end
            endcase
        end else if (prog_req && state_q == FCLC_UNLOCKED) begin
            if (prog_ok) begin
                state_d = FCLC_PROG;
                pgo_d   = 1'b1;
            end else begin
                prej_d  = 1'b1;
            end
        end
    end

    // Read data: status at the command address, guard or page choice at the shared one.
    always_comb begin
        rdata_d = rdata_q;
        if (reg_rd) begin
            if (reg_addr == `FCLC_ADDR_CMD) begin
                rdata_d = {2'b00, status_of(state_q)};
            end else if (reg_addr == `FCLC_ADDR_PAGE) begin
                rdata_d = (state_q == FCLC_GUARD_SEL) ? guard_q : page_q;
            end else begin
                rdata_d = `FCLC_RST_RDATA;
            end
        end
    end

    // All state clears on reset; guard bits otherwise clear only on a debugger write in guard select.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= FCLC_LOCKED;
            page_q  <= `FCLC_RST_PAGE;
            guard_q <= `FCLC_RST_GUARD;
            rdata_q <= `FCLC_RST_RDATA;
            pgo_q   <= 1'b0;
            prej_q  <= 1'b0;
            pe_q    <= 1'b0;
            me_q    <= 1'b0;
        end else begin
            state_q <= state_d;
            page_q  <= page_d;
            guard_q <= guard_d;
            rdata_q <= rdata_d;
            pgo_q   <= pgo_d;
            prej_q  <= prej_d;
            pe_q    <= pe_d;
            me_q    <= me_d;
        end
    end

    // Outputs all come straight from flip-flops.
    assign reg_rdata     = rdata_q;
    assign prog_go       = pgo_q;
    assign prog_refused  = prej_q;
    assign page_erase_go = pe_q;
    assign mass_erase_go = me_q;
    assign erase_page    = page_q[6:0];
    assign info_map_en   = page_q[`FCLC_INFO_BIT];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (sys_rst);

    first_code_a: assert property (
        (state_q == FCLC_LOCKED && cmd_wr && reg_wdata == `FCLC_CMD_UNLOCK1)
        |=> state_q == FCLC_FIRST)
        else $error("First unlock code did not advance the sequence.");

    page_erase_a: assert property (
        page_erase_go |-> ($past(state_q) == FCLC_UNLOCKED && $past(cmd_wr)
                           && $past(reg_wdata) == `FCLC_CMD_PAGE_ERASE
                           && state_q == FCLC_PERASE))
        else $error("Page erase started without its code after unlock.");

    mass_erase_a: assert property (
        mass_erase_go |-> ($past(state_q) == FCLC_UNLOCKED && $past(debugger_path)
                           && $past(reg_wdata) == `FCLC_CMD_MASS_ERASE))
        else $error("Mass erase started without a debugger code after unlock.");

    user_mass_a: assert property (
        (cmd_wr && !debugger_path && reg_wdata == `FCLC_CMD_MASS_ERASE && !busy)
        |=> !mass_erase_go ##1 state_q != FCLC_MERASE)
        else $error("User code reached mass erase.");

    bad_cmd_a: assert property (
        (cmd_wr && !busy && reg_wdata != `FCLC_CMD_UNLOCK1 && reg_wdata != `FCLC_CMD_UNLOCK2
         && reg_wdata != `FCLC_CMD_PAGE_ERASE && reg_wdata != `FCLC_CMD_MASS_ERASE
         && reg_wdata != `FCLC_CMD_GUARD_SEL) |=> state_q == FCLC_LOCKED)
        else $error("Unknown command did not lock the controller.");

    guard_route_a: assert property (
        (state_q == FCLC_GUARD_SEL && page_wr)
        |=> page_q == $past(page_q) && state_q == FCLC_LOCKED)
        else $error("Guard write leaked into the page choice.");

    status_rd_a: assert property (
        (reg_rd && reg_addr == `FCLC_ADDR_CMD)
        |=> reg_rdata == {2'b00, status_of($past(state_q))})
        else $error("Status read returned the wrong code.");

    guard_sticky_a: assert property (
        (page_wr && !debugger_path) |=> (guard_q & $past(guard_q)) == $past(guard_q))
        else $error("User write cleared a guard bit.");

    page_match_a: assert property (
        (state_q == FCLC_SECOND && page_wr && reg_wdata != page_q) |=> state_q == FCLC_LOCKED)
        else $error("Mismatched page choice still unlocked.");

    erase_lock_a: assert property (
        (state_q == FCLC_PERASE && flash_done) |=> state_q == FCLC_LOCKED)
        else $error("Finished page erase did not relock.");

    unlock_c: cover property (state_q == FCLC_SECOND ##[1:20] state_q == FCLC_UNLOCKED);
    perase_c: cover property (page_erase_go);
    merase_c: cover property (mass_erase_go);
    guard_c:  cover property (state_q == FCLC_GUARD_SEL && page_wr);

endmodule : fclc_ctrl

`default_nettype wire

// ===== verif/fclc_array_model.sv
// Flash array stand-in: answers each program or erase start with a one-cycle done pulse.
// Assumes start pulses last one ref_clk cycle and never arrive while an operation runs.
`default_nettype none

module fclc_array_model #(
    parameter int BUSY = 10
) (
    input  wire logic ref_clk,
    input  wire logic sys_rst,
    input  wire logic prog_go,
    input  wire logic page_erase_go,
    input  wire logic mass_erase_go,
    input  wire logic slow,
    output logic      flash_done
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [9:0] busy_q;

    // Any start loads the busy count; slow mode stretches it so status polls see a long busy code.
    always_ff @(posedge ref_clk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_q     <= 10'h000;
            flash_done <= 1'b0;
        end else begin
            flash_done <= (busy_q == 10'h001);
            if (prog_go | page_erase_go | mass_erase_go) begin
                busy_q <= slow ? 10'(BUSY * 8) : 10'(BUSY);
            end else if (busy_q != 10'h000) begin
                busy_q <= busy_q - 10'h001;
            end
        end
    end

endmodule : fclc_array_model

`default_nettype wire

// ===== verif/tb.sv
// Self-checking bench for the flash command block: register tasks and scenario sequences.
// Assumes the array model beside the block answers every start with a done pulse.
`default_nettype none
`define CHK(act, exp) begin num_checks++; if ((act) !== (exp)) begin mismatches++; \
    $display("Error at %0t: value %h expected %h", $time, act, exp); end end

module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import fclc_pkg::*;

    logic        ref_clk, sys_rst, reg_wr, reg_rd, debugger_path, slow;
    logic [11:0] reg_addr;
    logic [7:0]  reg_wdata, reg_rdata, q;
    fclc_mem_e   mem_cfg;
    logic        write_enable_opt, prog_req, prog_dbg, prog_go, prog_refused, flash_done;
    logic [15:0] prog_addr;
    logic        page_erase_go, mass_erase_go, info_map_en;
    logic [6:0]  erase_page;
    logic [7:0]  bad [4] = '{8'h00, 8'h95, 8'h63, 8'ha5};
    int          mismatches = 0, num_checks = 0, pe_cnt = 0, me_cnt = 0, exp_pe = 0;

    fclc_ctrl fclc_ctrl_inst (.ref_clk, .sys_rst, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
        .debugger_path, .reg_rdata, .mem_cfg, .write_enable_opt, .prog_req, .prog_addr,
        .prog_dbg, .prog_go, .prog_refused, .flash_done, .page_erase_go, .mass_erase_go,
        .erase_page, .info_map_en);

    fclc_array_model #(.BUSY(10)) fclc_array_model_inst (.ref_clk, .sys_rst, .prog_go,
        .page_erase_go, .mass_erase_go, .slow, .flash_done);

    // Free-running 200 MHz clock.
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end

    // Erase start pulses last one cycle, so they are counted here rather than polled.
    always @(posedge ref_clk) begin
        if (page_erase_go === 1'b1) pe_cnt++;
        if (mass_erase_go === 1'b1) me_cnt++;
    end

    task automatic results();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : results

    // One write, held for exactly one sampling edge; the gap cycle keeps strobes clean.
    task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic g);
        @(posedge ref_clk);
        reg_wr        <= 1'b1;
        reg_addr      <= a;
        reg_wdata     <= d;
        debugger_path <= g;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr

    task automatic rd(input logic [11:0] a, output logic [7:0] v);
        @(posedge ref_clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    task automatic st(input logic [7:0] e);
        logic [7:0] v;
        rd(12'hff8, v);
        `CHK(v, e)
    endtask : st

    task automatic prog(input logic [15:0] a, input logic g, input logic go);
        @(posedge ref_clk);
        prog_req  <= 1'b1;
        prog_addr <= a;
        prog_dbg  <= g;
        @(posedge ref_clk);
        prog_req <= 1'b0;
        #1;
        `CHK({prog_go, prog_refused}, {go, ~go})
    endtask : prog

    // A missing done pulse would hang the sequence, so the wait is bounded.
    task automatic wait_done();
        int i;
        for (i = 0; i < 500; i++) begin
            @(posedge ref_clk);
            if (flash_done === 1'b1) break;
        end
        if (i == 500) begin
            mismatches++;
            $display("Error at %0t: no done pulse from the array", $time);
            results();
        end
        #1;
    endtask : wait_done

    // Page choice, both codes, then the matching page choice unless the debugger unlocks.
    task automatic unlock(input logic [7:0] p, input logic g);
        wr(12'hff9, p, 1'b0);
        wr(12'hff8, 8'h73, 1'b0);
        wr(12'hff8, 8'h8c, g);
        if (!g) wr(12'hff9, p, 1'b0);
    endtask : unlock

    // Main sequence; each group ends in a known status before the next one starts.
    initial begin
        sys_rst = 1'b1;
        {reg_wr, reg_rd, debugger_path, prog_req, prog_dbg, slow} = 6'h00;
        reg_addr = 12'h000;
        reg_wdata = 8'h00;
        prog_addr = 16'h0000;
        mem_cfg = FCLC_MEM_8K;
        write_enable_opt = 1'b1;
        repeat (16) @(posedge ref_clk);
        sys_rst <= 1'b0;
        st(8'h00);
        rd(12'hff9, q);
        `CHK(q, 8'h00)
        wr(12'hff9, 8'h85, 1'b0);
        `CHK({info_map_en, erase_page}, 8'h85)
        wr(12'hff8, 8'h73, 1'b0);
        st(8'h01);
        wr(12'hff8, 8'h8c, 1'b0);
        st(8'h02);
        wr(12'hff9, 8'h85, 1'b0);
        st(8'h03);
        wr(12'hff9, 8'h06, 1'b0);
        `CHK(erase_page, 7'h05)
        prog(16'h0bff, 1'b0, 1'b1);
        st(8'h08);
        wait_done();
        st(8'h03);
        prog(16'h0c00, 1'b0, 1'b0);
        wr(12'hff8, 8'h95, 1'b0);
        exp_pe++;
        st(8'h10);
        wait_done();
        st(8'h00);
        wr(12'hff9, 8'h05, 1'b0);
        wr(12'hff8, 8'h73, 1'b0);
        wr(12'hff8, 8'h8c, 1'b0);
        wr(12'hff9, 8'h06, 1'b0);
        st(8'h00);
        foreach (bad[k]) begin
            wr(12'hff8, 8'h73, 1'b0);
            wr(12'hff8, bad[k], 1'b0);
            st(8'h00);
        end
        unlock(8'h00, 1'b0);
        wr(12'hff8, 8'ha5, 1'b0);
        st(8'h00);
        wr(12'hff8, 8'h95, 1'b0);
        st(8'h00);
        unlock(8'h00, 1'b0);
        wr(12'hff8, 8'h63, 1'b0);
        st(8'h00);
        `CHK(pe_cnt, exp_pe)
        `CHK(me_cnt, 0)
        wr(12'hff8, 8'h00, 1'b0);
        wr(12'hff8, 8'h5e, 1'b0);
        st(8'h04);
        wr(12'hff9, 8'h01, 1'b0);
        wr(12'hff9, 8'h02, 1'b0);
        `CHK(erase_page, 7'h02)
        wr(12'hff8, 8'h5e, 1'b0);
        rd(12'hff9, q);
        `CHK(q, 8'h01)
        wr(12'hff9, 8'h00, 1'b0);
        wr(12'hff8, 8'h5e, 1'b0);
        rd(12'hff9, q);
        `CHK(q, 8'h01)
        // Deselect the guard first, or the next page choice write would land in the guard.
        wr(12'hff8, 8'h00, 1'b0);
        mem_cfg <= FCLC_MEM_4K;
        write_enable_opt <= 1'b0;
        unlock(8'h01, 1'b0);
        wr(12'hff8, 8'h95, 1'b0);
        st(8'h00);
        write_enable_opt <= 1'b1;
        unlock(8'h01, 1'b0);
        wr(12'hff8, 8'h95, 1'b0);
        exp_pe++;
        st(8'h10);
        wait_done();
        mem_cfg <= FCLC_MEM_8K;
        unlock(8'h01, 1'b0);
        wr(12'hff8, 8'h95, 1'b0);
        st(8'h00);
        write_enable_opt <= 1'b0;
        unlock(8'h00, 1'b1);
        st(8'h03);
        prog(16'h0123, 1'b1, 1'b1);
        wait_done();
        prog(16'hab00, 1'b1, 1'b1);
        wait_done();
        wr(12'hff9, 8'h01, 1'b1);
        `CHK(erase_page, 7'h01)
        wr(12'hff8, 8'h95, 1'b1);
        exp_pe++;
        st(8'h10);
        wait_done();
        `CHK(pe_cnt, exp_pe)
        slow <= 1'b1;
        unlock(8'h00, 1'b1);
        wr(12'hff8, 8'h63, 1'b1);
        st(8'h20);
        wait_done();
        `CHK(me_cnt, 1)
        wr(12'hff8, 8'h5e, 1'b0);
        wr(12'hff9, 8'h00, 1'b1);
        wr(12'hff8, 8'h5e, 1'b0);
        rd(12'hff9, q);
        `CHK(q, 8'h00)
        results();
    end

endmodule : tb

`default_nettype wire
